// [hw/ush_pkg.sv]
// Shared constants and types of the frame list scheduler
`default_nettype none
package ush_pkg;
   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_NS        = 10;
   localparam int FRAME_NS      = 1000000;
   localparam int FRAME_CYCLES  = FRAME_NS / CLK_NS;
   // Rounded full-speed bit time, unit of the frame thresholds
   localparam int FS_BIT_NS     = 84;
   localparam int FS_BIT_CYCLES = (FS_BIT_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [9:0] EP_FRAME_MAX = 10'h3ff;
   // ****************************************
   // Command port
   // ****************************************
   localparam int CMD_WRITE_BIT = 7;
   localparam logic [6:0] REG_FM_INTERVAL  = 7'h0d;
   localparam logic [6:0] REG_LS_THRESHOLD = 7'h11;
   localparam logic [6:0] REG_HW_CFG       = 7'h20;
   localparam logic [6:0] REG_IRQ          = 7'h24;
   localparam logic [6:0] REG_ISO_LEN      = 7'h2a;
   localparam logic [6:0] REG_BUF_STATUS   = 7'h2c;
   localparam logic [6:0] REG_DESC_LOAD    = 7'h30;
   localparam logic [6:0] REG_SOFT_RESET   = 7'h31;
   localparam logic [6:0] PORT_ISO_BUF     = 7'h40;
   localparam logic [6:0] PORT_ASYNC_BUF   = 7'h41;
   // ****************************************
   // Fields and reset values
   // ****************************************
   localparam int FS_LARGEST_LSB = 16;
   localparam int FS_LARGEST_MSB = 30;
   localparam int LS_THR_MSB     = 11;
   localparam int HWCFG_OC_EN    = 10;
   localparam int HWCFG_PULLDOWN = 12;
   localparam int IRQ_ISO        = 0;
   localparam int IRQ_ASYNC      = 1;
   localparam int BST_ISO0_FULL  = 0;
   localparam int BST_ASYNC_FULL = 2;
   localparam int BST_ISO0_DONE  = 3;
   localparam int BST_ASYNC_DONE = 5;
   localparam int DESC_COUNT_MSB = 9;
   localparam int DESC_LS_BIT    = 10;
   localparam int DESC_SLOT_LSB  = 14;
   localparam logic [15:0] HW_CFG_RESET  = 16'h0000;
   localparam logic [31:0] FM_INT_RESET  = 32'h0000_0000;
   localparam logic [31:0] LS_THR_RESET  = 32'h0000_0000;
   localparam logic [15:0] ISO_LEN_RESET = 16'h0000;
   typedef enum logic [0:0] {SCHED_SCAN, SCHED_WAIT} ush_sched_type;
endpackage : ush_pkg
`default_nettype wire

// [hw/ush_word_buf.sv]
// Small word buffer between register port and USB side
`default_nettype none
module ush_word_buf #(
   parameter int WIDTH = 17,
   parameter int DEPTH = 2
) (
   // Clock and reset
   input  wire logic             core_clk,
   input  wire logic             rst_n,
   input  wire logic             ce,
   // Fill side
   input  wire logic             in_valid,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  in_ready,
   // Drain side
   output logic                  out_valid,
   output logic [WIDTH-1:0]      out_data,
   input  wire logic             out_ready
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wr;
      logic [AW-1:0]               rd;
      logic [AW:0]                 cnt;
   } ush_buf_state_type;
   ush_buf_state_type q, d;
   logic push, pop;

   always_comb begin
      d    = q;
      push = in_valid && in_ready;
      pop  = out_valid && out_ready;
      if (push) begin
         d.mem[q.wr] = in_data;
         d.wr = (q.wr == AW'(DEPTH - 1)) ? '0 : q.wr + 1'b1;
      end
      if (pop) begin
         d.rd = (q.rd == AW'(DEPTH - 1)) ? '0 : q.rd + 1'b1;
      end
      d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         q <= '0;
      end else if (ce) begin
         q <= d;
      end
   end

   assign in_ready  = (q.cnt != (AW+1)'(DEPTH));
   assign out_valid = (q.cnt != '0);
   assign out_data  = q.mem[q.rd];

   chk_buf_no_overflow: assert property (@(posedge core_clk) disable iff (!rst_n)
      q.cnt <= (AW+1)'(DEPTH)) else $error("word buffer overflow");
endmodule : ush_word_buf
`default_nettype wire

// [hw/ush_port_power.sv]
// Downstream port power switching from overcurrent sense
`default_nettype none
module ush_port_power #(
   parameter int PORTS = 2
) (
   // Clock and reset
   input  wire logic             core_clk,
   input  wire logic             rst_n,
   input  wire logic             ce,
   // Sense
   input  wire logic             internal_overcurrent_enable,
   input  wire logic [PORTS-1:0] overcurrent_n,
   input  wire logic [PORTS-1:0] analog_trip,
   // Open-drain switch pins
   output logic [PORTS-1:0]      power_switch_out,
   output logic [PORTS-1:0]      power_switch_oe
);
   typedef struct packed {
      logic [PORTS-1:0] sw_n;
   } ush_pwr_state_type;
   ush_pwr_state_type q, d;

   always_comb begin
      d = q;
      for (int i = 0; i < PORTS; i++) begin
         // High removes port power
         d.sw_n[i] = internal_overcurrent_enable ? analog_trip[i] : !overcurrent_n[i];
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         q <= '0;
      end else if (ce) begin
         q <= d;
      end
   end

   assign power_switch_out = '0;
   assign power_switch_oe  = ~q.sw_n;

   chk_oc_cuts_power: assert property (@(posedge core_clk) disable iff (!rst_n)
      ce && !internal_overcurrent_enable && !overcurrent_n[0] |=> !power_switch_oe[0])
      else $error("port power kept during overcurrent");
endmodule : ush_port_power
`default_nettype wire

// [hw/ush_frame_sched.sv]
// Frame list scheduler: registers, ping-pong status, async scheduling
`default_nettype none
// Operation
// - Frame end from largest packet and threshold
// - Mixed frames raise two interrupts
// - Iso interrupt set with start of frame
// - Async interrupt follows iso interrupt
// - Active clears on completion or fatal error
// - Re-service active descriptors while time remains
// - Iso write sets half full
// - Processed half sets done
// - Iso read clears full and done
// - Missed read stops iso until reset
// - Next start of frame marks done
// - Stale full and done auto cleared
// - Busy async defers async frame
// - Busy iso write suppresses async interrupt
// - At most 1023 bytes per endpoint frame
// - Pull-down select bit, reset clears
// - Overcurrent releases the open-drain power switch pin
// - Toggle iso half unless both full
module ush_frame_sched #(
   parameter int FRAME_CYCLES = ush_pkg::FRAME_CYCLES,
   parameter int SLOTS        = 4,
   parameter int MAX_PKT      = 64,
   parameter int PORTS        = 2
) (
   // Clock and reset
   input  wire logic             core_clk,
   input  wire logic             rst_n,
   input  wire logic             ce,
   // Processor command and data port
   input  wire logic             cmd_wr,
   input  wire logic [7:0]       cmd_code,
   input  wire logic             data_wr,
   input  wire logic [15:0]      data_wdata,
   input  wire logic             data_rd,
   output logic [15:0]           data_rdata,
   output logic                  data_rvalid,
   output logic                  host_wr_ready,
   // Interrupt bits
   output logic                  iso_list_irq,
   output logic                  async_list_irq,
   // USB side
   output logic                  sof_pulse,
   output logic                  iso_stalled,
   output logic                  txn_start,
   output logic [$clog2(SLOTS)-1:0] txn_slot,
   output logic [9:0]            txn_len,
   output logic                  txn_lowspeed,
   input  wire logic             txn_done,
   input  wire logic [9:0]       txn_bytes,
   input  wire logic             txn_fatal,
   output logic                  tx_valid,
   output logic [15:0]           tx_data,
   output logic                  tx_iso,
   input  wire logic             tx_ready,
   // Downstream ports
   input  wire logic [PORTS-1:0] overcurrent_n,
   input  wire logic [PORTS-1:0] analog_trip,
   output logic [PORTS-1:0]      power_switch_out,
   output logic [PORTS-1:0]      power_switch_oe,
   output logic                  internal_pulldown_select
);
   localparam int FW = $clog2(FRAME_CYCLES + 1);
   localparam int SW = $clog2(SLOTS);
   localparam int TW = FW + 4;

   typedef struct packed {
      logic [6:0]   cmd;
      logic         cmd_is_wr;
      logic         word_hi;
      logic [31:0]  fm_interval;
      logic [31:0]  ls_thr;
      logic [15:0]  hw_cfg;
      logic [15:0]  iso_len;
      logic         iso_irq;
      logic         async_irq;
      logic         async_owed;
      logic         async_run;
      logic         iso_busy;
      logic         async_busy;
      logic [1:0]   full;
      logic [1:0]   done;
      logic         async_full;
      logic         async_done;
      logic         proc_half;
      logic         dev_half;
      logic         dev_valid;
      logic         stalled;
      logic [FW-1:0] frame_left;
      logic         sof;
      logic [SLOTS-1:0] active;
      logic [SLOTS-1:0] ls;
      logic [SLOTS-1:0][9:0] left;
      logic [SLOTS-1:0][9:0] moved;
      logic [SW-1:0] ptr;
      ush_pkg::ush_sched_type st;
      logic         txn_start;
      logic [SW-1:0] txn_slot;
      logic [9:0]   txn_len;
      logic         txn_ls;
      logic [15:0]  rdata;
      logic         rvalid;
   } ush_sched_state_type;
   ush_sched_state_type q, d;

   logic        push_valid;
   logic [16:0] push_data;
   logic [16:0] pop_data;
   logic        iso_wr_ev, iso_rd_ev;

   // Half word of a 32-bit register
   function automatic logic [15:0] half_of(input logic [31:0] v, input logic hi);
      half_of = hi ? v[31:16] : v[15:0];
   endfunction : half_of

   // Enough frame time left for one more packet
   function automatic logic has_time(input logic [FW-1:0] rem, input logic [31:0] fm,
                                     input logic [31:0] lst, input logic lsp);
      logic [TW-1:0] need;
      need = '0;
      if (lsp) begin
         need = TW'(lst[ush_pkg::LS_THR_MSB:0]) * TW'(ush_pkg::FS_BIT_CYCLES);
      end else begin
         need = TW'(fm[ush_pkg::FS_LARGEST_MSB:ush_pkg::FS_LARGEST_LSB])
              * TW'(ush_pkg::FS_BIT_CYCLES);
      end
      has_time = TW'(rem) > need;
   endfunction : has_time

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      logic [9:0] lim;
      logic [9:0] room;
      logic [9:0] nl;
      logic [SW-1:0] sl;
      lim  = '0;
      room = '0;
      nl   = '0;
      sl   = '0;
      d    = q;
      d.sof       = 1'b0;
      d.txn_start = 1'b0;
      d.rvalid    = 1'b0;
      push_valid  = 1'b0;
      push_data   = {1'b0, data_wdata};
      iso_wr_ev   = data_wr && q.cmd_is_wr && (q.cmd == ush_pkg::PORT_ISO_BUF);
      iso_rd_ev   = data_rd && !q.cmd_is_wr && (q.cmd == ush_pkg::PORT_ISO_BUF);

      if (cmd_wr) begin
         d.cmd        = cmd_code[6:0];
         d.cmd_is_wr  = cmd_code[ush_pkg::CMD_WRITE_BIT];
         d.word_hi    = 1'b0;
         d.iso_busy   = (cmd_code[6:0] == ush_pkg::PORT_ISO_BUF);
         d.async_busy = (cmd_code[6:0] == ush_pkg::PORT_ASYNC_BUF);
      end

      // Register writes
      if (data_wr && q.cmd_is_wr) begin
         d.word_hi = !q.word_hi;
         case (q.cmd)
            ush_pkg::REG_FM_INTERVAL: begin
               if (q.word_hi) d.fm_interval[31:16] = data_wdata;
               else d.fm_interval[15:0] = data_wdata;
            end
            ush_pkg::REG_LS_THRESHOLD: begin
               if (q.word_hi) d.ls_thr[31:16] = data_wdata;
               else d.ls_thr[15:0] = data_wdata;
            end
            ush_pkg::REG_HW_CFG: d.hw_cfg = data_wdata;
            ush_pkg::REG_ISO_LEN: d.iso_len = data_wdata;
            ush_pkg::REG_IRQ: begin
               if (data_wdata[ush_pkg::IRQ_ISO]) d.iso_irq = 1'b0;
               if (data_wdata[ush_pkg::IRQ_ASYNC]) d.async_irq = 1'b0;
            end
            ush_pkg::REG_DESC_LOAD: begin
               sl = data_wdata[ush_pkg::DESC_SLOT_LSB +: SW];
               d.active[sl] = 1'b1;
               d.ls[sl]     = data_wdata[ush_pkg::DESC_LS_BIT];
               d.left[sl]   = data_wdata[ush_pkg::DESC_COUNT_MSB:0];
            end
            ush_pkg::PORT_ISO_BUF: begin
               push_valid = 1'b1;
               push_data  = {1'b1, data_wdata};
               if (host_wr_ready) d.full[q.proc_half] = 1'b1;
            end
            ush_pkg::PORT_ASYNC_BUF: begin
               push_valid = 1'b1;
               if (host_wr_ready) d.async_full = 1'b1;
            end
            default: d.word_hi = !q.word_hi;
         endcase
      end

      // Register reads
      if (data_rd && !q.cmd_is_wr) begin
         d.rvalid  = 1'b1;
         d.word_hi = !q.word_hi;
         case (q.cmd)
            ush_pkg::REG_FM_INTERVAL:  d.rdata = half_of(q.fm_interval, q.word_hi);
            ush_pkg::REG_LS_THRESHOLD: d.rdata = half_of(q.ls_thr, q.word_hi);
            ush_pkg::REG_HW_CFG:       d.rdata = q.hw_cfg;
            ush_pkg::REG_ISO_LEN:      d.rdata = q.iso_len;
            ush_pkg::REG_IRQ:          d.rdata = {14'h0000, q.async_irq, q.iso_irq};
            ush_pkg::REG_BUF_STATUS:
               d.rdata = {10'h000, q.async_done, q.done, q.async_full, q.full};
            ush_pkg::PORT_ISO_BUF: begin
               d.rdata = 16'h0000;
               d.full[q.proc_half] = 1'b0;
               d.done[q.proc_half] = 1'b0;
            end
            ush_pkg::PORT_ASYNC_BUF: begin
               d.rdata      = 16'h0000;
               d.async_full = 1'b0;
               d.async_done = 1'b0;
            end
            default: d.rdata = 16'h0000;
         endcase
      end

      // Frame timer and start of frame
      if (q.frame_left == '0) begin
         d.frame_left = FW'(FRAME_CYCLES - 1);
         d.sof        = 1'b1;
         d.iso_irq    = 1'b1;
         d.async_run  = !q.async_busy;
         d.async_owed = !(q.async_busy || q.iso_busy);
         d.moved      = '0;
         for (int h = 0; h < 2; h++) begin
            if (d.full[h] && d.done[h]) begin
               d.full[h]  = 1'b0;
               d.done[h]  = 1'b0;
               d.stalled  = 1'b1;
            end
         end
         if (q.dev_valid) d.done[q.dev_half] = 1'b1;
         d.dev_valid = !d.stalled && d.full[q.proc_half];
         d.dev_half  = q.proc_half;
         if (!(d.full[0] && d.full[1])) d.proc_half = !q.proc_half;
      end else begin
         d.frame_left = q.frame_left - 1'b1;
      end

      // Async interrupt once the iso interrupt is served
      if (q.async_owed && !q.iso_irq && !d.sof) begin
         d.async_irq  = 1'b1;
         d.async_owed = 1'b0;
      end

      // Async descriptor scheduling
      case (q.st)
         ush_pkg::SCHED_SCAN: begin
            room = ush_pkg::EP_FRAME_MAX - q.moved[q.ptr];
            lim  = (q.left[q.ptr] > 10'(MAX_PKT)) ? 10'(MAX_PKT) : q.left[q.ptr];
            if (lim > room) lim = room;
            if (q.async_run && q.active[q.ptr] && lim != '0 &&
                has_time(q.frame_left, q.fm_interval, q.ls_thr, q.ls[q.ptr])) begin
               d.txn_start = 1'b1;
               d.txn_slot  = q.ptr;
               d.txn_len   = lim;
               d.txn_ls    = q.ls[q.ptr];
               d.st        = ush_pkg::SCHED_WAIT;
            end else begin
               d.ptr = (q.ptr == SW'(SLOTS - 1)) ? '0 : q.ptr + 1'b1;
            end
            if (q.async_run && q.active == '0) d.async_done = 1'b1;
         end
         ush_pkg::SCHED_WAIT: begin
            if (txn_done) begin
               nl = (txn_bytes > q.left[q.txn_slot]) ? '0 : q.left[q.txn_slot] - txn_bytes;
               d.left[q.txn_slot]  = nl;
               d.moved[q.txn_slot] = q.moved[q.txn_slot] + txn_bytes;
               if (nl == '0 || txn_fatal) d.active[q.txn_slot] = 1'b0;
               d.ptr = (q.ptr == SW'(SLOTS - 1)) ? '0 : q.ptr + 1'b1;
               d.st  = ush_pkg::SCHED_SCAN;
            end
         end
         default: d.st = ush_pkg::SCHED_SCAN;
      endcase

      // Software reset restores the scheduler registers, pull-down select included
      if (data_wr && q.cmd_is_wr && q.cmd == ush_pkg::REG_SOFT_RESET) begin
         d = '0;
         d.hw_cfg = ush_pkg::HW_CFG_RESET;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         q             <= '0;
         q.fm_interval <= ush_pkg::FM_INT_RESET;
         q.ls_thr      <= ush_pkg::LS_THR_RESET;
         q.hw_cfg      <= ush_pkg::HW_CFG_RESET;
         q.iso_len     <= ush_pkg::ISO_LEN_RESET;
      end else if (ce) begin
         q <= d;
      end
   end

   // ****************************************
   // Sub-blocks and outputs
   // ****************************************
   ush_word_buf #(.WIDTH(17), .DEPTH(2)) u_buf (
      .core_clk  (core_clk),
      .rst_n     (rst_n),
      .ce        (ce),
      .in_valid  (push_valid && ce),
      .in_data   (push_data),
      .in_ready  (host_wr_ready),
      .out_valid (tx_valid),
      .out_data  (pop_data),
      .out_ready (tx_ready && ce)
   );

   ush_port_power #(.PORTS(PORTS)) u_pwr (
      .core_clk                    (core_clk),
      .rst_n                       (rst_n),
      .ce                          (ce),
      .internal_overcurrent_enable (q.hw_cfg[ush_pkg::HWCFG_OC_EN]),
      .overcurrent_n               (overcurrent_n),
      .analog_trip                 (analog_trip),
      .power_switch_out            (power_switch_out),
      .power_switch_oe             (power_switch_oe)
   );

   assign tx_data                  = pop_data[15:0];
   assign tx_iso                   = pop_data[16];
   assign data_rdata               = q.rdata;
   assign data_rvalid              = q.rvalid;
   assign iso_list_irq             = q.iso_irq;
   assign async_list_irq           = q.async_irq;
   assign sof_pulse                = q.sof;
   assign iso_stalled              = q.stalled;
   assign txn_start                = q.txn_start;
   assign txn_slot                 = q.txn_slot;
   assign txn_len                  = q.txn_len;
   assign txn_lowspeed             = q.txn_ls;
   assign internal_pulldown_select = q.hw_cfg[ush_pkg::HWCFG_PULLDOWN];

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   chk_sof_iso_irq: assert property (q.sof |-> q.iso_irq)
      else $error("iso interrupt missing at start of frame");
   chk_iso_wr_full: assert property (ce && iso_wr_ev && host_wr_ready
      && q.frame_left != '0 |=> q.full[$past(q.proc_half)])
      else $error("iso write did not set full");
   chk_iso_rd_clear: assert property (ce && iso_rd_ev && !cmd_wr
      && q.frame_left != '0 |=> !q.full[$past(q.proc_half)] && !q.done[$past(q.proc_half)])
      else $error("iso read did not clear status");
   chk_stall_no_iso: assert property (q.sof && q.stalled |-> !q.dev_valid)
      else $error("iso processing while stalled");
   chk_done_at_sof: assert property (ce && q.frame_left == '0 && q.dev_valid
      && !data_wr |=> q.done[$past(q.dev_half)])
      else $error("processed half not marked done");
   chk_no_toggle_full: assert property (ce && q.frame_left == '0 && q.full == 2'b11 &&
      !iso_rd_ev && !q.done[0] && !q.done[1] && !data_wr
      |=> q.proc_half == $past(q.proc_half))
      else $error("half toggled with both full");
   chk_async_defer: assert property (ce && q.frame_left == '0 && q.async_busy
      && !cmd_wr && !data_wr |=> !q.async_run && !q.async_owed)
      else $error("async frame not deferred");
   chk_async_after_iso: assert property ($rose(q.async_irq) |-> !$past(q.iso_irq))
      else $error("async interrupt before iso served");
   chk_frame_cap: assert property (q.txn_start |->
      (11'(q.txn_len) + 11'(q.moved[q.txn_slot])) <= 11'(ush_pkg::EP_FRAME_MAX))
      else $error("endpoint frame byte cap exceeded");
   chk_active_kept: assert property (ce && q.st == ush_pkg::SCHED_WAIT && txn_done &&
      !txn_fatal && txn_bytes < q.left[q.txn_slot] && !data_wr
      |=> q.active[$past(q.txn_slot)])
      else $error("active cleared with data left");
   chk_pulldown_reset: assert property (@(posedge core_clk) disable iff (1'b0)
      !rst_n |=> !internal_pulldown_select)
      else $error("pull-down select not cleared by reset");

   cov_two_irqs: cover property (q.sof ##[1:1000] $rose(q.async_irq));
   cov_stall: cover property ($rose(q.stalled));
   cov_both_full: cover property (q.sof && q.full == 2'b11);
   cov_retry: cover property (q.txn_start ##[1:50] q.txn_start && q.txn_slot == $past(q.txn_slot));
endmodule : ush_frame_sched
`default_nettype wire

// [bench/ush_usb_model.sv]
// USB-side responder: answers transactions and stalls the word stream
`default_nettype none
module ush_usb_model (
   // Clock and reset
   input  wire logic       core_clk,
   input  wire logic       rst_n,
   // Transactions
   input  wire logic       txn_start,
   input  wire logic [9:0] txn_len,
   output logic            txn_done,
   output logic [9:0]      txn_bytes,
   output logic            txn_fatal,
   // Word stream
   output logic            tx_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   int unsigned wait_q;
   logic [9:0]  len_q;
   initial begin
      {txn_done, txn_fatal, tx_ready} = 3'b000;
      txn_bytes = 10'h3ff;
      wait_q = 0;
      len_q = 10'h000;
   end
   always @(posedge core_clk) begin
      tx_ready <= 1'($urandom);
      txn_done <= 1'b0;
      txn_bytes <= ~len_q;
      if (!rst_n) begin
         wait_q <= 0;
      end else if (txn_start) begin
         wait_q <= 2 + $urandom % 6;
         len_q <= txn_len;
      end else if (wait_q == 1) begin
         txn_done <= 1'b1;
         txn_bytes <= len_q;
         wait_q <= 0;
      end else if (wait_q > 1) begin
         wait_q <= wait_q - 1;
      end
   end
endmodule : ush_usb_model
`default_nettype wire

// [bench/tb.sv]
// Self-checking bench of the frame list scheduler
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int FC = 200;
   logic clk, rst_n, cmd_wr, data_wr, data_rd, rvalid, iso_irq, as_irq, sof, stall, start;
   logic done, fatal, ready, pd;
   logic [7:0]  cmd_code;
   logic [15:0] wdata, rdata, v;
   logic [1:0]  slot, oc_n, trip, psw_out, psw_oe;
   logic [9:0]  len, bytes;
   logic [9:0]  lens[$];
   logic [16:0] txw[$];
   logic        tvalid, tiso;
   logic [15:0] tdata;
   int errors, total_checks, i;
   ush_frame_sched #(.FRAME_CYCLES(FC)) ush_frame_sched_i (.core_clk(clk), .rst_n(rst_n),
      .ce(1'b1), .cmd_wr(cmd_wr), .cmd_code(cmd_code), .data_wr(data_wr), .data_wdata(wdata),
      .data_rd(data_rd), .data_rdata(rdata), .data_rvalid(rvalid), .host_wr_ready(),
      .iso_list_irq(iso_irq), .async_list_irq(as_irq), .sof_pulse(sof), .iso_stalled(stall),
      .txn_start(start), .txn_slot(slot), .txn_len(len), .txn_lowspeed(), .txn_done(done),
      .txn_bytes(bytes), .txn_fatal(fatal), .tx_valid(tvalid), .tx_data(tdata), .tx_iso(tiso),
      .tx_ready(ready), .overcurrent_n(oc_n), .analog_trip(trip), .power_switch_out(psw_out),
      .power_switch_oe(psw_oe), .internal_pulldown_select(pd));
   ush_usb_model ush_usb_model_i (.core_clk(clk), .rst_n(rst_n), .txn_start(start),
      .txn_len(len), .txn_done(done), .txn_bytes(bytes), .txn_fatal(fatal), .tx_ready(ready));
   always @(negedge clk) begin
      if (start === 1'b1) lens.push_back(len);
      if (tvalid === 1'b1 && ready === 1'b1) txw.push_back({tiso, tdata});
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // Kind 0 command, 1 write, 2 read into v
   task automatic acc(input int k, input logic [15:0] d);
      {cmd_wr, data_wr, data_rd} = {k == 0, k == 1, k == 2};
      cmd_code = d[7:0];
      wdata = d;
      @(posedge clk);
      #1 {cmd_wr, data_wr, data_rd} = 3'b000;
      if (k == 2) chk(rvalid, 1);
      @(posedge clk);
      #1 v = rdata;
   endtask : acc
   task automatic wait_sof();
      int n;
      n = 0;
      do begin
         @(posedge clk);
         #1 n++;
      end while (sof !== 1'b1 && n < 3 * FC);
      chk(sof, 1);
   endtask : wait_sof
   task automatic results();
      $display("checks=%0d errors=%0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : results
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      #200us errors++;
      results();
   end
   initial begin
      {rst_n, cmd_wr, data_wr, data_rd, cmd_code, wdata} = '0;
      {oc_n, trip, errors, total_checks} = {4'hc, 64'h0};
      i = $urandom(32'h3c46);
      repeat (6) @(posedge clk);
      #1 rst_n = 1'b1;
      acc(0, 8'h20); acc(2, 0); chk(v, 16'h0000);
      chk(pd, 0);
      acc(0, 8'h7f); acc(2, 0); chk(v, 16'h0000);
      for (i = 0; i < 6; i++) begin
         oc_n = 2'($urandom);
         repeat (3) @(posedge clk);
         #1 chk(psw_oe, oc_n);
         chk(psw_out, 0);
      end
      acc(0, 8'ha0); acc(1, 16'h1400);
      chk(pd, 1);
      acc(0, 8'h20); acc(2, 0); chk(v, 16'h1400);
      for (i = 0; i < 6; i++) begin
         trip = 2'($urandom);
         repeat (3) @(posedge clk);
         #1 chk(psw_oe, 2'(~trip));
      end
      acc(0, 8'ha4); acc(1, 16'h0003);
      chk(as_irq, 1);
      acc(1, 16'h0002);
      wait_sof();
      chk(iso_irq, 1);
      chk(as_irq, 0);
      acc(0, 8'ha4); acc(1, 16'h0001);
      chk(as_irq, 1);
      acc(0, 8'hc0); acc(1, 16'h1234);
      acc(0, 8'h2c); acc(2, 0); chk(^v[1:0], 1);
      acc(0, 8'h40); acc(2, 0); acc(0, 8'h2c); acc(2, 0);
      chk(v & 16'h001b, 0);
      acc(0, 8'hb0); acc(1, {2'b01, 4'h0, 10'd100});
      for (i = 0; i < 3 * FC && lens.size() < 2; i++) @(posedge clk);
      #1 chk(lens.size(), 2);
      chk(lens[0], 64);
      chk(lens[1], 36);
      acc(0, 8'hc0); acc(1, 16'h5a5a);
      repeat (4) wait_sof();
      #20 acc(0, 8'h2c); acc(2, 0); chk(v & 16'h001b, 0);
      chk(stall, 1);
      acc(0, 8'ha4);
      acc(1, 16'h0003);
      chk(as_irq, 0);
      acc(0, 8'hc1);
      acc(1, 16'h0f0f);
      wait_sof();
      acc(0, 8'ha4);
      acc(1, 16'h0001);
      chk(as_irq, 0);
      acc(0, 8'hb1); acc(1, 0);
      chk({stall, pd}, 0);
      chk(txw.size(), 3);
      chk(txw[0][15:0], 16'h1234);
      chk(txw[1][15:0], 16'h5a5a);
      chk({txw[0][16], txw[1][16], txw[2][16]}, 3'b110);
      results();
   end
endmodule : tb
`default_nettype wire
